// ===== common/tsdr_pkg.sv
// Package with register map, field layout and timing constants of the touch sensor result bank.
package tsdr_pkg;
  localparam logic [7:0] CH1_LOW_ADDR      = 8'h04;  // Channel 1 result, low byte.
  localparam logic [7:0] CH1_HIGH_ADDR     = 8'h05;  // Channel 1 result, high nibble.
  localparam logic [7:0] CH2_LOW_ADDR      = 8'h06;  // Channel 2 result, low byte.
  localparam logic [7:0] CH2_HIGH_ADDR     = 8'h07;  // Channel 2 result, high nibble.
  localparam logic [7:0] CH3_LOW_ADDR      = 8'h08;  // Channel 3 result, low byte.
  localparam logic [7:0] CH3_HIGH_ADDR     = 8'h09;  // Channel 3 result, high nibble.
  localparam logic [7:0] CTRL_ADDR         = 8'h0A;  // Reset and control register.
  localparam int         FULL_RESET_BIT    = 4;      // Position of the full reset bit.
  localparam int         CONFIG_HOLD_BIT   = 0;      // Position of the configuration hold bit.
  localparam logic [7:0] CTRL_WR_MASK      = 8'h11;  // Passes the two defined bits; the reset bit never stays set.
  localparam logic [7:0] CTRL_RESET        = 8'h00;  // Control register reset value.
  localparam logic [11:0] SAMPLE_RESET     = 12'h000; // Result reset value.
  localparam logic [11:0] SAMPLE_POS_MAX   = 12'h7FF; // Most positive result code.
  localparam logic [11:0] SAMPLE_NEG_MAX   = 12'h800; // Most negative result code.
  localparam int         CLK_HZ            = 20000000; // Internal clock rate.
  localparam int         READY_DELAY_NS    = 1000;   // Settling time after a full reset.
  localparam int         READY_CYCLES      = (READY_DELAY_NS * (CLK_HZ / 1000000) + 999) / 1000;

  // A register bus access as seen by the serial port front end.
  typedef struct packed {
    logic       wr;    // Write strobe, one cycle.
    logic       rd;    // Read strobe, one cycle.
    logic [7:0] addr;  // Register address.
    logic [7:0] wdata; // Write data.
  } tsdr_access_t;

  // One conversion result delivered by the converter.
  typedef struct packed {
    logic        valid; // Result valid, one cycle.
    logic [1:0]  chan;  // Channel number, 1 to 3 used here.
    logic [11:0] value; // Two's-complement result.
  } tsdr_sample_t;
endpackage : tsdr_pkg

// ===== design/tsdr_regs.sv
// Result registers for channels 1 to 3 and the reset/control register.
`timescale 1ns/1ps
//
// Operation
// - Low byte holds result bits seven to zero.
// - High register holds bits eleven to eight.
// - Channels two and three only on four-channel part.
// - Results are read-only and reset to zero.
// - Control bit four resets whole device.
// - No conversions until ready flag reads one.
// - Control bit zero holds conversions off.
// - Configuration mode keeps register settings unchanged.
// - Ready flag one when ready, else zero.
// - Saturation flag on extreme result codes.
module tsdr_regs #(
  parameter bit FOUR_CHAN    = 1'b1,                 // One for the four-channel variant.
  parameter int READY_CYCLES = tsdr_pkg::READY_CYCLES // Cycles from full reset to ready.
) (
  input  wire logic                   ref_clk,         // Internal 20 MHz clock.
  input  wire logic                   rstn,            // Asynchronous reset, active low.
  input  wire tsdr_pkg::tsdr_access_t bus,             // Register access from the port.
  output logic [7:0]                  rdata,           // Registered read data.
  input  wire tsdr_pkg::tsdr_sample_t sample,          // New conversion result.
  input  wire logic                   status_read,     // Status register read, clears flag.
  output logic                        conv_enable,     // High while conversions may run.
  output logic                        chip_ready,      // Ready flag for the status register.
  output logic                        saturation_flag, // Sticky saturation flag.
  output logic                        dev_reset_pulse  // One-cycle reset to the rest of chip.
);
  localparam int CW = $clog2(READY_CYCLES + 1); // Counter width.

  logic [11:0]   sample_reg [1:3];  // Stored results per channel.
  logic [11:0]   sample_next [1:3]; // Next results per channel.
  logic [7:0]    ctrl_reg;          // Control register.
  logic [7:0]    ctrl_next;         // Next control value.
  logic [CW-1:0] wait_reg;          // Cycles left until ready.
  logic [CW-1:0] wait_next;         // Next wait count.
  logic          ready_reg;         // Ready state.
  logic          ready_next;        // Next ready state.
  logic          sat_reg;           // Saturation state.
  logic          sat_next;          // Next saturation state.
  logic [7:0]    rdata_reg;         // Read data holding register.
  logic [7:0]    rdata_next;        // Next read data.
  logic          rst_pulse_reg;     // Reset pulse register.
  logic          rst_pulse_next;    // Next reset pulse.
  logic          conv_en_reg;       // Conversion enable, registered for a clean output.
  logic          conv_en_next;      // Next conversion enable.
  logic          ctrl_wr;           // Write to control register this cycle.
  logic          full_reset;        // Software full reset requested.
  logic          accept;            // A result may be stored.

  assign ctrl_wr    = bus.wr && (bus.addr == tsdr_pkg::CTRL_ADDR);
  assign full_reset = ctrl_wr && bus.wdata[tsdr_pkg::FULL_RESET_BIT];
  // Results only land while not held and ready; channel 2 and 3 need the larger part.
  assign accept = sample.valid && ready_reg && !ctrl_reg[tsdr_pkg::CONFIG_HOLD_BIT]
                  && (sample.chan != 2'h0)
                  && (FOUR_CHAN || sample.chan == 2'h1);

  // Result storage; a full reset clears every result to its default.
  always_comb
  begin
    for (int i = 1; i <= 3; i++)
    begin
      sample_next[i] = sample_reg[i];
      if (full_reset)
      begin
        sample_next[i] = tsdr_pkg::SAMPLE_RESET;
      end
      else if (accept && sample.chan == 2'(i))
      begin
        sample_next[i] = sample.value;
      end
    end
  end

  // The result registers have no write path, so host writes never reach them.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 1; i <= 3; i++)
      begin
        sample_reg[i] <= tsdr_pkg::SAMPLE_RESET;
      end
    end
    else
    begin
      for (int i = 1; i <= 3; i++)
      begin
        sample_reg[i] <= sample_next[i];
      end
    end
  end

  // Control, ready and saturation state.
  always_comb
  begin
    ctrl_next      = ctrl_reg;
    wait_next      = wait_reg;
    ready_next     = ready_reg;
    sat_next       = sat_reg;
    rst_pulse_next = full_reset;
    if (full_reset)
    begin
      // The reset bit self-clears because the control register returns to its default.
      ctrl_next  = tsdr_pkg::CTRL_RESET;
      wait_next  = CW'(READY_CYCLES);
      ready_next = 1'b0;
      sat_next   = 1'b0;
    end
    else
    begin
      if (ctrl_wr)
      begin
        // Only the hold bit is stored; reserved bits read as zero. Holding changes nothing else.
        ctrl_next = bus.wdata & tsdr_pkg::CTRL_WR_MASK;
      end
      if (!ready_reg)
      begin
        if (wait_reg <= CW'(1))
        begin
          ready_next = 1'b1;
          wait_next  = '0;
        end
        else
        begin
          wait_next = wait_reg - CW'(1);
        end
      end
      if (status_read)
      begin
        sat_next = 1'b0;
      end
      // A saturating result in the clearing cycle still sets the flag.
      if (accept && (sample.value == tsdr_pkg::SAMPLE_POS_MAX ||
                     sample.value == tsdr_pkg::SAMPLE_NEG_MAX))
      begin
        sat_next = 1'b1;
      end
    end
    // The enable is built from the next values so that the registered output
    // falls at the same edge as the hold bit or the ready flag, not one later.
    conv_en_next = ready_next && !ctrl_next[tsdr_pkg::CONFIG_HOLD_BIT];
  end

  // Control, ready, saturation and enable registers; out of reset the part is ready.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_reg      <= tsdr_pkg::CTRL_RESET;
      wait_reg      <= '0;
      ready_reg     <= 1'b1;
      sat_reg       <= 1'b0;
      rst_pulse_reg <= 1'b0;
      conv_en_reg   <= 1'b1;
    end
    else
    begin
      ctrl_reg      <= ctrl_next;
      wait_reg      <= wait_next;
      ready_reg     <= ready_next;
      sat_reg       <= sat_next;
      rst_pulse_reg <= rst_pulse_next;
      conv_en_reg   <= conv_en_next;
    end
  end

  // Read mux; reserved nibbles are forced to zero.
  always_comb
  begin
    rdata_next = 8'h00;
    if (bus.rd)
    begin
      case (bus.addr)
        tsdr_pkg::CH1_LOW_ADDR:  rdata_next = sample_reg[1][7:0];
        tsdr_pkg::CH1_HIGH_ADDR: rdata_next = {4'h0, sample_reg[1][11:8]};
        tsdr_pkg::CH2_LOW_ADDR:  rdata_next = sample_reg[2][7:0];
        tsdr_pkg::CH2_HIGH_ADDR: rdata_next = {4'h0, sample_reg[2][11:8]};
        tsdr_pkg::CH3_LOW_ADDR:  rdata_next = sample_reg[3][7:0];
        tsdr_pkg::CH3_HIGH_ADDR: rdata_next = {4'h0, sample_reg[3][11:8]};
        tsdr_pkg::CTRL_ADDR:     rdata_next = ctrl_reg;
        default:                 rdata_next = 8'h00;
      endcase
    end
  end

  // Read data register; it returns to zero in any cycle without a read.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata_reg <= 8'h00;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata           = rdata_reg;
  assign chip_ready      = ready_reg;
  assign saturation_flag = sat_reg;
  assign dev_reset_pulse = rst_pulse_reg;
  assign conv_enable     = conv_en_reg;

  // Checks. Each property is sampled on the internal clock and is off while rstn is low,
  // so none of them has to reason about the reset values being loaded.

  // A full reset returns control to default, drops ready and raises the pulse.
  chk_reset_clears_ctrl: assert property (@(posedge ref_clk) disable iff (!rstn)
    full_reset |=> (ctrl_reg == 8'h00) && !ready_reg && dev_reset_pulse)
    else $error("full reset did not clear control");

  // Every stored result goes back to zero on a full reset.
  chk_reset_clears_data: assert property (@(posedge ref_clk) disable iff (!rstn)
    full_reset |=> sample_reg[1] == 12'h000 && sample_reg[2] == 12'h000
                   && sample_reg[3] == 12'h000)
    else $error("full reset did not clear results");

  // The hold bit blocks both the enable and the storing of results.
  chk_hold_blocks_conv: assert property (@(posedge ref_clk) disable iff (!rstn)
    ctrl_reg[0] |-> !conv_enable && !accept)
    else $error("conversion accepted while held");

  // A result offered before ready leaves every channel as it was.
  chk_not_ready_blocks: assert property (@(posedge ref_clk) disable iff (!rstn)
    !ready_reg && sample.valid && !full_reset |=> $stable(sample_reg[1])
      && $stable(sample_reg[2]) && $stable(sample_reg[3]))
    else $error("result stored before ready");

  // Ready comes back within a bounded settle time after it drops.
  chk_ready_returns: assert property (@(posedge ref_clk) disable iff (!rstn)
    $fell(ready_reg) |-> ##[1:1000] ready_reg)
    else $error("ready flag never returned");

  // The upper nibble of a high result register always reads zero.
  chk_high_reserved: assert property (@(posedge ref_clk) disable iff (!rstn)
    bus.rd && bus.addr == tsdr_pkg::CH2_HIGH_ADDR |=> rdata[7:4] == 4'h0)
    else $error("reserved result bits not zero");

  // A low byte read returns result bits seven to zero.
  chk_low_byte_read: assert property (@(posedge ref_clk) disable iff (!rstn)
    bus.rd && bus.addr == tsdr_pkg::CH1_LOW_ADDR |=> rdata == $past(sample_reg[1][7:0]))
    else $error("low byte read mismatch");

  // A high register read returns result bits eleven to eight.
  chk_high_nibble_read: assert property (@(posedge ref_clk) disable iff (!rstn)
    bus.rd && bus.addr == tsdr_pkg::CH3_HIGH_ADDR |=> rdata[3:0] == $past(sample_reg[3][11:8]))
    else $error("high nibble read mismatch");

  // On the two-channel part the upper channels never hold data.
  chk_two_chan_idle: assert property (@(posedge ref_clk) disable iff (!rstn)
    !FOUR_CHAN |-> sample_reg[2] == 12'h000 && sample_reg[3] == 12'h000)
    else $error("absent channel holds data");

  // The most positive code raises the saturation flag.
  chk_saturation_set: assert property (@(posedge ref_clk) disable iff (!rstn)
    accept && !full_reset && sample.value == 12'h7FF |=> saturation_flag)
    else $error("saturation not flagged");

  // Entering hold keeps the stored results; a result landing that cycle is excluded.
  chk_hold_keeps_data: assert property (@(posedge ref_clk) disable iff (!rstn)
    ctrl_wr && bus.wdata == 8'h01 && !accept |=> $stable(sample_reg[1]) && ctrl_reg == 8'h01)
    else $error("config mode altered settings");

  // The most negative code raises the saturation flag as well.
  chk_sat_neg_code: assert property (@(posedge ref_clk) disable iff (!rstn)
    accept && !full_reset && sample.value == 12'h800 |=> saturation_flag)
    else $error("negative saturation not flagged");

  // A status read with no saturating result that cycle clears the flag.
  chk_sat_read_clears: assert property (@(posedge ref_clk) disable iff (!rstn)
    status_read && !accept && !full_reset |=> !saturation_flag)
    else $error("saturation flag not cleared by read");

  // The reset pulse lasts one cycle unless a new full reset follows.
  chk_reset_pulse_once: assert property (@(posedge ref_clk) disable iff (!rstn)
    dev_reset_pulse && !full_reset |=> !dev_reset_pulse)
    else $error("reset pulse longer than one cycle");

  // An accepted channel 2 result is stored whole in the next cycle.
  chk_result_stored: assert property (@(posedge ref_clk) disable iff (!rstn)
    accept && !full_reset && sample.chan == 2'h2 |=> sample_reg[2] == $past(sample.value))
    else $error("accepted result not stored");

  // A full reset also clears the saturation flag and stops conversions.
  chk_reset_clears_flag: assert property (@(posedge ref_clk) disable iff (!rstn)
    full_reset |=> !saturation_flag && !conv_enable)
    else $error("full reset left flag or enable set");

  // The two-channel part drops results for channels it does not have.
  chk_absent_chan_drop: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample.valid && !FOUR_CHAN && sample.chan != 2'h1 |-> !accept)
    else $error("absent channel result accepted");

  // While not ready the conversion enable stays low.
  chk_ready_blocks_enable: assert property (@(posedge ref_clk) disable iff (!rstn)
    !ready_reg |-> !conv_enable)
    else $error("conversions enabled before ready");

  // Reserved control bits and the self-clearing reset bit always read zero.
  chk_ctrl_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
    ctrl_reg[7:1] == 7'h00)
    else $error("reserved control bits stored");
endmodule : tsdr_regs

// ===== tb/tsdr_host.sv
// Host model that reaches the register bank through its register access port.
`timescale 1ns/1ps
module tsdr_host (
  input  wire logic              ref_clk, // Device clock.
  output tsdr_pkg::tsdr_access_t bus,     // Access request toward the bank.
  input  wire logic [7:0]        rdata    // Registered read data from the bank.
);
  // The bus idles from time zero so no stray strobe reaches the bank.
  initial bus = '0;

  // Write one register; the strobe is taken at exactly one edge.
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge ref_clk);
    #1 bus = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge ref_clk);
    #1 bus = '0;
  endtask : wr

  // Read one register; data stands for the cycle after the taking edge.
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge ref_clk);
    #1 bus = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge ref_clk);
    #1 data = rdata;
    bus = '0;
  endtask : rd

  // Control writes always carry zeros in the reserved fields.
  task automatic ctrl(input logic hold, input logic full);
    wr(tsdr_pkg::CTRL_ADDR, {3'h0, full, 3'h0, hold});
  endtask : ctrl
endmodule : tsdr_host

// ===== tb/tb_touch_sensor_data_reset_regs.sv
// Self-checking bench for the result and control register bank.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin miscompares++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module tb_touch_sensor_data_reset_regs;
  localparam int RDY = 4;          // Short settle count keeps the run brief.
  logic                   ref_clk; // Bench clock.
  logic                   rstn;    // Reset, active low.
  tsdr_pkg::tsdr_access_t bus;     // Host access.
  logic [7:0]             rdata;   // Read data.
  tsdr_pkg::tsdr_sample_t sample;  // Converter result.
  logic [7:0]             rdata_two; // Read data of the two-channel variant.
  logic                   status_read, conv_enable, chip_ready, saturation_flag, dev_reset_pulse;
  int                     miscompares = 0; // Mismatches seen.
  int                     compares = 0;    // Comparisons made.
  int                     cycles = 0;      // Cycles run, for the hang guard.

  tsdr_host u_host (.ref_clk(ref_clk), .bus(bus), .rdata(rdata));
  tsdr_regs #(.FOUR_CHAN(1'b1), .READY_CYCLES(RDY)) u_dut (.ref_clk(ref_clk), .rstn(rstn),
    .bus(bus), .rdata(rdata), .sample(sample), .status_read(status_read),
    .conv_enable(conv_enable), .chip_ready(chip_ready), .saturation_flag(saturation_flag),
    .dev_reset_pulse(dev_reset_pulse));

  // Two-channel variant on the same bus and feed; only its read data is watched.
  tsdr_regs #(.FOUR_CHAN(1'b0), .READY_CYCLES(RDY)) u_dut_two (.ref_clk(ref_clk), .rstn(rstn),
    .bus(bus), .rdata(rdata_two), .sample(sample), .status_read(status_read),
    .conv_enable(), .chip_ready(), .saturation_flag(), .dev_reset_pulse());

  // Free-running 20 MHz clock.
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Hang guard; the whole sequence needs well under a thousand cycles.
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      finish_test();
    end
  end

  // Prints the verdict and ends the run.
  task automatic finish_test();
    if (miscompares == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  // Reads a register and compares it with the expected byte.
  task automatic check_reg(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    u_host.rd(addr, d);
    `CHK("register read", exp, d)
  endtask : check_reg

  // Reads over the shared bus and compares the two-channel variant's answer.
  task automatic check_two(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    u_host.rd(addr, d);
    `CHK("two-channel read", exp, rdata_two)
  endtask : check_two

  // Delivers one conversion result as a single-cycle pulse.
  task automatic send(input logic [1:0] ch, input logic [11:0] val);
    @(posedge ref_clk);
    #1 sample = '{valid: 1'b1, chan: ch, value: val};
    @(posedge ref_clk);
    #1 sample = '0;
  endtask : send

  // Status read pulse, which clears the sticky saturation flag.
  task automatic clear_status();
    @(posedge ref_clk);
    #1 status_read = 1'b1;
    @(posedge ref_clk);
    #1 status_read = 1'b0;
  endtask : clear_status

  // Every mapped register and one unmapped place read zero after reset.
  task automatic t_reset();
    for (int a = 4; a <= 11; a++) check_reg(a[7:0], 8'h00);
    `CHK("chip_ready", 1'b1, chip_ready)
    `CHK("conv_enable", 1'b1, conv_enable)
  endtask : t_reset

  // Results sent one after another land split over low byte and high nibble.
  task automatic t_results();
    send(2'd1, 12'h5A3);
    send(2'd2, 12'h9F1);
    send(2'd3, 12'hABC);
    check_reg(tsdr_pkg::CH1_LOW_ADDR, 8'hA3);
    check_reg(tsdr_pkg::CH1_HIGH_ADDR, 8'h05);
    check_reg(tsdr_pkg::CH2_LOW_ADDR, 8'hF1);
    check_reg(tsdr_pkg::CH2_HIGH_ADDR, 8'h09);
    check_reg(tsdr_pkg::CH3_LOW_ADDR, 8'hBC);
    check_reg(tsdr_pkg::CH3_HIGH_ADDR, 8'h0A);
    check_two(tsdr_pkg::CH1_LOW_ADDR, 8'hA3);
    check_two(tsdr_pkg::CH2_LOW_ADDR, 8'h00);
    check_two(tsdr_pkg::CH3_HIGH_ADDR, 8'h00);
    u_host.wr(tsdr_pkg::CH1_HIGH_ADDR, 8'hFF);
    check_reg(tsdr_pkg::CH1_HIGH_ADDR, 8'h05);
    `CHK("saturation_flag", 1'b0, saturation_flag)
  endtask : t_results

  // Both extreme codes raise the flag; one step short of the positive one does not.
  task automatic t_saturate();
    send(2'd1, 12'h7FF);
    `CHK("saturation_flag", 1'b1, saturation_flag)
    clear_status();
    `CHK("saturation_flag", 1'b0, saturation_flag)
    send(2'd2, 12'h800);
    `CHK("saturation_flag", 1'b1, saturation_flag)
    clear_status();
    send(2'd3, 12'h7FE);
    `CHK("saturation_flag", 1'b0, saturation_flag)
    // A saturating result in the same cycle as a status read must still set the flag.
    @(posedge ref_clk);
    #1 status_read = 1'b1;
    sample = '{valid: 1'b1, chan: 2'd1, value: 12'h7FF};
    @(posedge ref_clk);
    #1 status_read = 1'b0;
    sample = '0;
    `CHK("saturation_flag", 1'b1, saturation_flag)
    clear_status();
  endtask : t_saturate

  // Hold mode drops results and keeps stored values untouched.
  task automatic t_hold();
    u_host.ctrl(1'b1, 1'b0);
    check_reg(tsdr_pkg::CTRL_ADDR, 8'h01);
    `CHK("conv_enable", 1'b0, conv_enable)
    send(2'd1, 12'h123);
    check_reg(tsdr_pkg::CH1_LOW_ADDR, 8'hFF);
    check_reg(tsdr_pkg::CH1_HIGH_ADDR, 8'h07);
    u_host.ctrl(1'b0, 1'b0);
    `CHK("conv_enable", 1'b1, conv_enable)
    send(2'd1, 12'h123);
    check_reg(tsdr_pkg::CH1_LOW_ADDR, 8'h23);
  endtask : t_hold

  // Full reset with hold set restores defaults and blocks results until ready.
  task automatic t_full_reset();
    int n;
    n = 0;
    send(2'd1, 12'h7FF);
    `CHK("saturation_flag", 1'b1, saturation_flag)
    u_host.ctrl(1'b1, 1'b1);
    `CHK("dev_reset_pulse", 1'b1, dev_reset_pulse)
    `CHK("chip_ready", 1'b0, chip_ready)
    `CHK("saturation_flag", 1'b0, saturation_flag)
    send(2'd1, 12'h7FF);
    `CHK("dev_reset_pulse", 1'b0, dev_reset_pulse)
    while (chip_ready !== 1'b1 && n < 50)
    begin
      @(posedge ref_clk);
      #1 n++;
    end
    // Ready rises exactly RDY edges after the reset write; the send took two of them.
    `CHK("ready delay", RDY, n + 2)
    `CHK("saturation_flag", 1'b0, saturation_flag)
    check_reg(tsdr_pkg::CH1_LOW_ADDR, 8'h00);
    check_reg(tsdr_pkg::CTRL_ADDR, 8'h00);
    check_reg(tsdr_pkg::CH2_HIGH_ADDR, 8'h00);
    check_reg(tsdr_pkg::CH3_LOW_ADDR, 8'h00);
    `CHK("conv_enable", 1'b1, conv_enable)
  endtask : t_full_reset

  // Main sequence: reset for ten cycles, then each scenario in turn.
  initial
  begin
    rstn = 1'b0;
    sample = '0;
    status_read = 1'b0;
    repeat (10) @(posedge ref_clk);
    #1 rstn = 1'b1;
    t_reset();
    t_results();
    t_saturate();
    t_hold();
    t_full_reset();
    finish_test();
  end
endmodule : tb_touch_sensor_data_reset_regs
